// ===== hdl/isf_status_flags.sv
// status-flag logic of a two-wire serial bus controller, with APB slave
`timescale 1ns/1ns
// ************************************************************
// Notes on behaviour
// - range enabled: nonzero address in range sets flag
// - control_one write clears range flag; a same-cycle range call wins
// - slave direction shows received read/write bit
// - pending flag set by events, write-one clears
// - fast ack off: flag after ack bit
// - written ack control drives ack or nack
// - fast ack on: flag after eight bits
// - any slave address match sets pending flag
// - smbus timeouts set flag, except high ones
// - receive acknowledge recorded after transmitted byte
// - arbitration-lost flag set, write-one clears
// ************************************************************
module isf_status_flags
  import isf_pkg::*;
#(
  parameter int ADDR_W = ISF_ADDR_W
) (
  input  wire logic              clk,             // 250 MHz module clock
  input  wire logic              reset,           // synchronous, active high
  input  wire logic              psel,            // apb select
  input  wire logic              penable,         // apb access phase
  input  wire logic              pwrite,          // apb direction
  input  wire logic [7:0]        paddr,           // apb byte address
  input  wire logic [31:0]       pwdata,          // apb write data
  output logic                   pready,          // apb ready
  output logic [31:0]            prdata,          // apb read data
  output logic                   pslverr,         // apb error on unmapped
  input  wire logic              addrValid,       // pulse: calling address taken
  input  wire logic [ADDR_W-1:0] callAddr,        // received calling address
  input  wire logic              callRw,          // read/write bit of it
  input  wire logic              alertMatch,      // alert response matched
  input  wire logic              secondMatch,     // second slave address matched
  input  wire logic              generalCall,     // general call matched
  input  wire logic              byteDataDone,    // pulse: eight data bits done
  input  wire logic              byteAckDone,     // pulse: ack bit done
  input  wire logic              txMode,          // device is transmitting
  input  wire logic              ackSampled,      // sda level at ack bit
  input  wire logic              arbLost,         // pulse: arbitration lost
  input  wire logic              lowTimeout,      // pulse: clock-low style timeout
  input  wire logic              clkHighTimeout,  // pulse: clock-high timeout
  input  wire logic              dataHighTimeout, // pulse: data-high timeout
  output logic                   ackDrive,        // ack level to drive, 1 = nack
  output logic                   moduleIrqEnable, // control_one irq enable
  output logic                   irq              // level interrupt
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic                arbitrationLostFlag;
    logic                rangeMatchFlag;
    logic                slaveDirection;
    logic                irqPendingFlag;
    logic                rxAckStatus;
    logic [ISF_REG_W-1:0] controlOne;
    logic [ISF_REG_W-1:0] controlTwo;
    logic [ADDR_W-1:0]   primarySlaveAddress;
    logic [ADDR_W-1:0]   upperRangeAddress;
    logic [ISF_EV_W-1:0] evtStatus;
    logic [ISF_EV_W-1:0] evtMask;
    logic                irq;
  } isf_state_t;

  isf_state_t s;
  isf_state_t next_s;

  // ************************************************************
  // decode helpers
  // ************************************************************
  logic                setupPhase;
  logic                wrDone;
  logic                mapped;
  logic                primaryHit;
  logic                rangeHit;
  logic                anyMatch;
  logic                byteEvent;
  logic                timeoutEvent;
  logic [ISF_EV_W-1:0] evtSet;
  logic [31:0]         readWord;

  always_comb begin
    setupPhase = psel && !penable;
    wrDone     = psel && penable && s.pready && pwrite;
    mapped     = (paddr == ISF_OFS_STATUS) || (paddr == ISF_OFS_CTRL1)
              || (paddr == ISF_OFS_CTRL2) || (paddr == ISF_OFS_ADDR1)
              || (paddr == ISF_OFS_RANGE) || (paddr == ISF_OFS_EVT)
              || (paddr == ISF_OFS_MASK);
    primaryHit = (callAddr == s.primarySlaveAddress);
    // range covers above the primary address up to the upper one
    rangeHit   = s.controlTwo[ISF_C2_RANGE_MATCH_ENABLE] && (callAddr != '0)
              && ((callAddr == s.upperRangeAddress)
              || ((callAddr > s.primarySlaveAddress)
              && (callAddr <= s.upperRangeAddress)));
    anyMatch   = addrValid && (primaryHit || rangeHit || alertMatch
              || secondMatch || generalCall);
    // fast ack moves the flag ahead of the ack bit so software can choose it
    byteEvent  = s.controlTwo[ISF_C2_FAST_ACK_SELECT] ? byteDataDone : byteAckDone;
    // high timeouts only mean idle bus, so they never interrupt
    timeoutEvent = s.controlTwo[ISF_C2_SMB] && lowTimeout;
    evtSet = '0;
    evtSet[ISF_EV_BYTE]    = byteEvent;
    evtSet[ISF_EV_MATCH]   = anyMatch;
    evtSet[ISF_EV_ARB]     = arbLost;
    evtSet[ISF_EV_TIMEOUT] = timeoutEvent;
  end

  // ************************************************************
  // read multiplexer
  // ************************************************************
  always_comb begin
    readWord = ISF_RST_WORD;
    case (paddr)
      ISF_OFS_STATUS: begin
        readWord[ISF_ST_ARBITRATION_LOST_FLAG] = s.arbitrationLostFlag;
        readWord[ISF_ST_RAM]  = s.rangeMatchFlag;
        readWord[ISF_ST_SRW]  = s.slaveDirection;
        readWord[ISF_ST_IRQ]  = s.irqPendingFlag;
        readWord[ISF_ST_RX_ACK_STATUS] = s.rxAckStatus;
      end
      ISF_OFS_CTRL1: readWord[ISF_REG_W-1:0] = s.controlOne;
      ISF_OFS_CTRL2: readWord[ISF_REG_W-1:0] = s.controlTwo;
      ISF_OFS_ADDR1: readWord[ADDR_W:1] = s.primarySlaveAddress;
      ISF_OFS_RANGE: readWord[ADDR_W:1] = s.upperRangeAddress;
      ISF_OFS_EVT:   readWord[ISF_EV_W-1:0] = s.evtStatus;
      ISF_OFS_MASK:  readWord[ISF_EV_W-1:0] = s.evtMask;
      default:       readWord = ISF_RST_WORD;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_s = s;
    // zero-wait slave: answer prepared in setup, shown in first access cycle
    next_s.pready  = setupPhase;
    next_s.pslverr = setupPhase && !mapped;
    next_s.prdata  = setupPhase ? readWord : ISF_RST_WORD;

    // clears from software first, so hardware sets below win a tie
    if (wrDone) begin
      case (paddr)
        ISF_OFS_STATUS: begin
          if (pwdata[ISF_ST_ARBITRATION_LOST_FLAG]) begin
            next_s.arbitrationLostFlag = 1'b0;
          end
          if (pwdata[ISF_ST_IRQ]) begin
            next_s.irqPendingFlag = 1'b0;
          end
        end
        ISF_OFS_CTRL1: begin
          next_s.controlOne     = pwdata[ISF_REG_W-1:0];
          next_s.rangeMatchFlag = 1'b0;
        end
        ISF_OFS_CTRL2: next_s.controlTwo = pwdata[ISF_REG_W-1:0];
        ISF_OFS_ADDR1: next_s.primarySlaveAddress = pwdata[ADDR_W:1];
        ISF_OFS_RANGE: next_s.upperRangeAddress = pwdata[ADDR_W:1];
        ISF_OFS_EVT:   next_s.evtStatus = s.evtStatus & ~pwdata[ISF_EV_W-1:0];
        ISF_OFS_MASK:  next_s.evtMask = pwdata[ISF_EV_W-1:0];
        default: begin
        end
      endcase
    end

    // set after the clear above, so a call beats a control_one write
    if (addrValid && rangeHit) begin
      next_s.rangeMatchFlag = 1'b1;
    end
    if (anyMatch) begin
      next_s.slaveDirection = callRw;
    end
    if (byteAckDone && txMode) begin
      next_s.rxAckStatus = ackSampled;
    end
    if (arbLost) begin
      next_s.arbitrationLostFlag = 1'b1;
    end
    if (|evtSet) begin
      next_s.irqPendingFlag = 1'b1;
    end
    next_s.evtStatus = next_s.evtStatus | evtSet;
    next_s.irq       = |(next_s.evtStatus & s.evtMask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign pready          = s.pready;
  assign prdata          = s.prdata;
  assign pslverr         = s.pslverr;
  assign ackDrive        = s.controlOne[ISF_C1_TX_ACK_CONTROL];
  assign moduleIrqEnable = s.controlOne[ISF_C1_IRQEN];
  assign irq             = s.irq;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence seq_setup;
    psel && !penable;
  endsequence

  sequence seq_ctrl1_write;
    psel && penable && pready && pwrite && (paddr == ISF_OFS_CTRL1);
  endsequence

  sequence seq_range_hit;
    addrValid && rangeHit;
  endsequence

  a_apb_zero_wait: assert property (seq_setup |=> pready)
    else $error("apb answer not in first access cycle");

  a_range_sets: assert property (seq_range_hit |=> s.rangeMatchFlag)
    else $error("range match flag not set");

  a_ctrl1_clears: assert property (seq_ctrl1_write ##0 !(addrValid && rangeHit)
                                   |=> !s.rangeMatchFlag)
    else $error("control_one write did not clear range flag");

  a_dir_tracks: assert property (anyMatch |=> s.slaveDirection == $past(callRw))
    else $error("slave direction not captured");

  a_fast_ack_select_off: assert property (!s.controlTwo[ISF_C2_FAST_ACK_SELECT] && byteAckDone
                               |=> s.irqPendingFlag)
    else $error("pending not set after ack bit");

  a_fast_ack_select_on: assert property (s.controlTwo[ISF_C2_FAST_ACK_SELECT] && byteDataDone
                              |=> s.irqPendingFlag)
    else $error("pending not set after eight bits");

  a_match_irq: assert property (anyMatch |=> s.irqPendingFlag && s.evtStatus[ISF_EV_MATCH])
    else $error("address match did not set pending");

  a_high_quiet: assert property (!s.irqPendingFlag && (clkHighTimeout || dataHighTimeout)
                                 && !(|evtSet) |=> !s.irqPendingFlag)
    else $error("high timeout set pending");

  a_rx_ack_status_rec: assert property (byteAckDone && txMode
                               |=> s.rxAckStatus == $past(ackSampled))
    else $error("acknowledge bit not recorded");

  a_arb_flags: assert property (arbLost |=> s.arbitrationLostFlag && s.irqPendingFlag)
    else $error("arbitration loss not flagged");

  // irq lags one edge, so it pairs current flags with the mask seen before
  a_irq_level: assert property (irq == |(s.evtStatus & $past(s.evtMask)))
    else $error("interrupt output mismatch");

  a_irq_masked: assert property (s.evtMask == '0 |=> !irq)
    else $error("interrupt raised with every source masked");

  a_evt_arb: assert property (arbLost |=> s.evtStatus[ISF_EV_ARB])
    else $error("arbitration loss not recorded as event");

  // ************************************************************
  // register bus handshake
  // ************************************************************
  // one-cycle answer; a ready held high would let a write land twice
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");

  // error rides with ready; writes to holes change nothing
  a_err_unmapped: assert property (seq_setup ##0 !mapped |=> pslverr)
    else $error("unmapped address not refused");

  a_err_mapped: assert property (seq_setup ##0 mapped |=> !pslverr)
    else $error("mapped address refused");

  // read data is zero outside the answer so an or-tree of slaves stays clean
  a_rd_idle_zero: assert property (!pready |-> prdata == ISF_RST_WORD)
    else $error("read data outside answer cycle");

  // ************************************************************
  // software clears and sticky flags
  // ************************************************************
  sequence seq_status_write;
    psel && penable && pready && pwrite && (paddr == ISF_OFS_STATUS);
  endsequence

  // clear and hardware set in one cycle: the set is kept, so no event here
  a_pend_w1c: assert property (seq_status_write ##0 (pwdata[ISF_ST_IRQ] && !(|evtSet))
                               |=> !s.irqPendingFlag)
    else $error("pending flag not cleared by write of one");

  a_arbitration_lost_flag_w1c: assert property (seq_status_write ##0 (pwdata[ISF_ST_ARBITRATION_LOST_FLAG] && !arbLost)
                               |=> !s.arbitrationLostFlag)
    else $error("arbitration flag not cleared by write of one");

  // write of one is the only way down; reads must not touch the flags
  a_pend_sticky: assert property (s.irqPendingFlag
      && !(wrDone && (paddr == ISF_OFS_STATUS) && pwdata[ISF_ST_IRQ])
      |=> s.irqPendingFlag)
    else $error("pending flag dropped without a clear");

  a_arb_sticky: assert property (s.arbitrationLostFlag
      && !(wrDone && (paddr == ISF_OFS_STATUS) && pwdata[ISF_ST_ARBITRATION_LOST_FLAG])
      |=> s.arbitrationLostFlag)
    else $error("arbitration flag dropped without a clear");

  a_ram_sticky: assert property (s.rangeMatchFlag && !(wrDone && (paddr == ISF_OFS_CTRL1))
                                 |=> s.rangeMatchFlag)
    else $error("range flag dropped without a control_one write");

  a_pend_quiet: assert property (!s.irqPendingFlag && !(|evtSet) |=> !s.irqPendingFlag)
    else $error("pending flag set with no event");

  // range matching off: the range flag cannot appear
  a_ram_off: assert property (!s.controlTwo[ISF_C2_RANGE_MATCH_ENABLE] && !s.rangeMatchFlag
                              |=> !s.rangeMatchFlag)
    else $error("range flag set with range matching off");

  a_smb_tmo: assert property (s.controlTwo[ISF_C2_SMB] && lowTimeout
                              |=> s.irqPendingFlag && s.evtStatus[ISF_EV_TIMEOUT])
    else $error("timeout did not set pending");

  // stale qualifiers on an idle strobe must not move these
  a_dir_hold: assert property (!anyMatch |=> $stable(s.slaveDirection))
    else $error("slave direction changed without a call");

  // received acknowledge only means something after a byte we sent
  a_rx_ack_status_hold: assert property (!(byteAckDone && txMode) |=> $stable(s.rxAckStatus))
    else $error("acknowledge status changed without a sent byte");

  a_ack_ctrl: assert property (seq_ctrl1_write
                               |=> ackDrive == $past(pwdata[ISF_C1_TX_ACK_CONTROL]))
    else $error("ack level does not follow control_one");

endmodule

// ===== inc/isf_pkg.sv
// shared constants for the two-wire bus status-flag block
package isf_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] ISF_OFS_STATUS = 8'h00;
  localparam logic [7:0] ISF_OFS_CTRL1  = 8'h04;
  localparam logic [7:0] ISF_OFS_CTRL2  = 8'h08;
  localparam logic [7:0] ISF_OFS_ADDR1  = 8'h0C;
  localparam logic [7:0] ISF_OFS_RANGE  = 8'h10;
  localparam logic [7:0] ISF_OFS_EVT    = 8'h14;
  localparam logic [7:0] ISF_OFS_MASK   = 8'h18;

  // ************************************************************
  // bus_status field positions
  // ************************************************************
  localparam int ISF_ST_ARBITRATION_LOST_FLAG = 4;
  localparam int ISF_ST_RAM  = 3;
  localparam int ISF_ST_SRW  = 2;
  localparam int ISF_ST_IRQ  = 1;
  localparam int ISF_ST_RX_ACK_STATUS = 0;

  // ************************************************************
  // control_one and control-two field positions
  // ************************************************************
  localparam int ISF_C1_IRQEN = 6;
  localparam int ISF_C1_TX_ACK_CONTROL  = 3;
  localparam int ISF_C2_RANGE_MATCH_ENABLE  = 3;
  localparam int ISF_C2_SMB   = 1;
  localparam int ISF_C2_FAST_ACK_SELECT  = 0;

  // ************************************************************
  // event status / mask layout
  // ************************************************************
  localparam int ISF_EV_BYTE    = 0;
  localparam int ISF_EV_MATCH   = 1;
  localparam int ISF_EV_ARB     = 2;
  localparam int ISF_EV_TIMEOUT = 3;
  localparam int ISF_EV_W       = 4;

  // ************************************************************
  // widths and reset values
  // ************************************************************
  localparam int ISF_REG_W  = 8;
  localparam int ISF_ADDR_W = 7;
  localparam logic [7:0] ISF_RST_REG = 8'h00;
  localparam logic [31:0] ISF_RST_WORD = 32'h0000_0000;

endpackage

// ===== verif/isf_bus_model.sv
// behavioural remote bus party feeding the status-flag block
`timescale 1ns/1ns
module isf_bus_model
  import isf_pkg::*;
(
  input  wire logic                  clk,        // module clock
  input  wire logic                  ackDrive,   // ack level the device drives
  output logic [ISF_ADDR_W-1:0]      callAddr,   // received calling address
  output logic                       addrValid,  // address strobe
  output logic [3:0]                 addrQual,   // rw, alert, second, general
  output logic [5:0]                 evPulse,    // data, ack, arb, low, scl hi, sda hi
  output logic                       txMode,     // device sent the byte
  output logic                       ackSampled  // sda at ack bit
);
  initial begin
    callAddr = '0;
    addrValid = 1'h0;
    addrQual = 4'h0;
    evPulse = 6'h00;
    txMode = 1'h0;
    ackSampled = 1'h1;
  end

  task automatic addr(input logic [ISF_ADDR_W-1:0] a, input logic [3:0] q);
    @(posedge clk);
    callAddr <= a;
    addrQual <= q;
    addrValid <= 1'h1;
    @(posedge clk);
    addrValid <= 1'h0;
    // stale values must never be mistaken for a new call
    callAddr <= ~a;
    addrQual <= ~q;
  endtask

  task automatic ev(input int i);
    @(posedge clk);
    evPulse[i] <= 1'h1;
    @(posedge clk);
    evPulse <= 6'h00;
  endtask

  task automatic xfer(input logic tx, input logic b);
    @(posedge clk);
    txMode <= tx;
    @(posedge clk);
    ackSampled <= tx ? b : ackDrive;
    evPulse[1] <= 1'h1;
    @(posedge clk);
    evPulse <= 6'h00;
    ackSampled <= ~ackSampled;
  endtask
endmodule

// ===== verif/tb.sv
// self-checking bench for the two-wire bus status-flag block
`timescale 1ns/1ns
module tb;
  import isf_pkg::*;
  logic                  clk, reset, psel, penable, pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata;
  logic                  pready, pslverr, addrValid, txMode, ackSampled;
  logic                  ackDrive, moduleIrqEnable, irq;
  logic [ISF_ADDR_W-1:0] callAddr;
  logic [3:0]            addrQual;
  logic [5:0]            evPulse;
  logic [64:0]           mon;
  logic [64:0]           expQ[$];
  int                    fail_count = 0;
  int                    checks_done = 0;

  isf_status_flags isf_status_flags_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .addrValid(addrValid),
    .callAddr(callAddr), .callRw(addrQual[3]), .alertMatch(addrQual[2]),
    .secondMatch(addrQual[1]), .generalCall(addrQual[0]),
    .byteDataDone(evPulse[0]), .byteAckDone(evPulse[1]), .txMode(txMode),
    .ackSampled(ackSampled), .arbLost(evPulse[2]), .lowTimeout(evPulse[3]),
    .clkHighTimeout(evPulse[4]), .dataHighTimeout(evPulse[5]),
    .ackDrive(ackDrive), .moduleIrqEnable(moduleIrqEnable), .irq(irq));

  isf_bus_model isf_bus_model_i (.clk(clk), .ackDrive(ackDrive), .callAddr(callAddr),
    .addrValid(addrValid), .addrQual(addrQual), .evPulse(evPulse), .txMode(txMode),
    .ackSampled(ackSampled));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // read expects d under mask m; a write sends d and only checks pslverr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic er);
    int n;
    @(posedge clk);
    expQ.push_back({er, m, d});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d, 32'h0, 1'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'h0, a, e, m, 1'h0);
  endtask

  task automatic clr();
    wr(ISF_OFS_STATUS, 32'h12);
    wr(ISF_OFS_EVT, 32'h0F);
    wr(ISF_OFS_CTRL1, 32'h40);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready) begin
      if (expQ.size() == 0) chk("queue", 32'h1, 32'h0);
      else begin
        mon = expQ.pop_front();
        chk("pslverr", {31'h0, mon[64]}, {31'h0, pslverr});
        chk("prdata", mon[31:0] & mon[63:32], prdata & mon[63:32]);
      end
    end
  end

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    logic [7:0] offs [7];
    offs = '{ISF_OFS_STATUS, ISF_OFS_CTRL1, ISF_OFS_CTRL2, ISF_OFS_ADDR1,
             ISF_OFS_RANGE, ISF_OFS_EVT, ISF_OFS_MASK};
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'h1, 43'h0};
    void'($urandom(20));
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    for (int i = 0; i < 7; i++) rd(offs[i], ISF_RST_WORD, 32'hFFFFFFFF);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'h1, 8'h1C, 32'hFF, 32'h0, 1'h1);
    apb(1'h0, 8'h1C, 32'h0, 32'hFFFFFFFF, 1'h1);
    wr(ISF_OFS_ADDR1, 32'h20);
    wr(ISF_OFS_RANGE, 32'h40);
    wr(ISF_OFS_CTRL2, 32'h08);
    wr(ISF_OFS_CTRL1, 32'h48);
    @(negedge clk);
    chk("ackDrive", 32'h1, {31'h0, ackDrive});
    chk("moduleIrqEnable", 32'h1, {31'h0, moduleIrqEnable});
    isf_bus_model_i.addr(7'h11 + 7'($urandom % 16), 4'h8);
    rd(ISF_OFS_STATUS, 32'h0E, 32'h0E);
    wr(ISF_OFS_CTRL1, 32'h40);
    @(negedge clk);
    chk("ackDrive", 32'h0, {31'h0, ackDrive});
    rd(ISF_OFS_STATUS, 32'h06, 32'h0E);
    wr(ISF_OFS_STATUS, 32'h02);
    rd(ISF_OFS_STATUS, 32'h00, 32'h02);
    isf_bus_model_i.addr(7'h20, 4'h0);
    rd(ISF_OFS_STATUS, 32'h0A, 32'h0E);
    clr();
    isf_bus_model_i.addr(7'h10, 4'h0);
    rd(ISF_OFS_STATUS, 32'h02, 32'h0A);
    clr();
    isf_bus_model_i.addr(7'h30, 4'h0);
    rd(ISF_OFS_STATUS, 32'h00, 32'h0A);
    for (int i = 0; i < 3; i++) begin
      clr();
      isf_bus_model_i.addr(7'h30, 4'h4 >> i);
      rd(ISF_OFS_STATUS, 32'h02, 32'h02);
    end
    for (int f = 0; f < 2; f++) begin
      wr(ISF_OFS_CTRL2, 32'h08 | f);
      clr();
      isf_bus_model_i.ev(f);
      rd(ISF_OFS_STATUS, 32'h00, 32'h02);
      isf_bus_model_i.ev(1 - f);
      rd(ISF_OFS_STATUS, 32'h02, 32'h02);
    end
    wr(ISF_OFS_CTRL2, 32'h00);
    clr();
    isf_bus_model_i.addr(7'h20, 4'h0);
    rd(ISF_OFS_STATUS, 32'h00, 32'h0A);
    wr(ISF_OFS_CTRL2, 32'h0A);
    for (int t = 3; t < 6; t++) begin
      clr();
      isf_bus_model_i.ev(t);
      rd(ISF_OFS_STATUS, (t == 3) ? 32'h02 : 32'h00, 32'h02);
    end
    clr();
    wr(ISF_OFS_MASK, 32'h04);
    isf_bus_model_i.ev(2);
    repeat (2) @(negedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(ISF_OFS_STATUS, 32'h12, 32'h12);
    rd(ISF_OFS_EVT, 32'h04, 32'h0F);
    wr(ISF_OFS_STATUS, 32'h10);
    rd(ISF_OFS_STATUS, 32'h02, 32'h12);
    wr(ISF_OFS_EVT, 32'h04);
    repeat (2) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ISF_OFS_MASK, 32'h00);
    isf_bus_model_i.ev(2);
    repeat (2) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    for (int k = 0; k < 2; k++) begin
      isf_bus_model_i.xfer(1'h1, k[0]);
      rd(ISF_OFS_STATUS, {31'h0, k[0]}, 32'h01);
    end
    isf_bus_model_i.xfer(1'h0, 1'h0);
    rd(ISF_OFS_STATUS, 32'h01, 32'h01);
    stop_test();
  end
endmodule
